// ===== design/asf_pkg.sv
/*
 Package for the sample FIFO status and readout block: offsets, field positions,
 reset values, thresholds and the carrier structs.
 Assumes a byte-wide I/O register port on a single 10 MHz clock.
*/
package asf_pkg;
    localparam logic [3:0] OFS_DATA = 4'h0;
    localparam logic [3:0] OFS_CHAN = 4'h2;
    localparam logic [3:0] OFS_CLRINT = 4'h8;
    localparam logic [3:0] OFS_FLAGS = 4'ha;
    localparam logic [3:0] OFS_COUNTLO = 4'hf;
    localparam int BIT_INT = 7;
    localparam int BIT_FRAG = 6;
    localparam int BIT_FULL = 5;
    localparam int BIT_EMPTY = 4;
    localparam int BLOCK_SHIFT = 8;
    localparam int LEGACY_THRESH = 512;
    localparam logic RST_INT = 1'b0;
    localparam logic RST_FRAG = 1'b0;
    localparam logic RST_FULL = 1'b0;
    localparam logic RST_EMPTY = 1'b1;
    localparam logic [11:0] RST_BLOCKS = 12'h000;
    localparam int FRAG_DEPTH_DEF = 16;
    localparam int FIFO_DEPTH_DEF = 4096;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } asf_bus_t;

    typedef struct packed {
        logic irqFlag;
        logic fragReady;
        logic fullFlag;
        logic emptyFlag;
        logic [11:0] blocks;
    } asf_status_t;
endpackage : asf_pkg

// ===== design/asf_sample_fifo.sv
/*
 Sample FIFO with fragment staging buffer, status registers and FIFO interrupt.
 Assumes the host bus strobes arrive synchronous to sys_clk, one cycle each.
*/
`timescale 1ns/10ps
// Notes on behaviour
// RQ1: Legacy mode raises the FIFO interrupt bit at 512 or more queued samples.
// RQ2: Nonzero threshold select raises the interrupt at a larger block count.
// RQ3: Interrupt bit always readable; drives the IRQ line only when enabled. Code returns it at 0xA only with the jumper.
// RQ4: Any write to the clear register clears the interrupt bit; reset zero. Code keeps the bit set while at or above threshold.
// RQ5: Fragment ready flag set while the staging buffer holds data; reset zero.
// RQ6: Full flag set once the FIFO fills or overflows; reset zero.
// RQ7: Empty flag one at reset and when empty, zero while samples present.
// RQ8: Report whole 256-sample blocks remaining in the FIFO.
// RQ9: Block count low byte at offset 0xF, upper four bits at 0xA.
// RQ10: Offset 0xA: interrupt D7, fragment D6, full D5, empty D4, count below.
// RQ11: Status registers exist only with the superset jumper installed.
// RQ12: Any channel register write resets the FIFO to its empty state.
// RQ13: Stage data in a fragment buffer so bursts need no wait states.
// RQ14: Wait states only when a burst outruns the fragment buffer.
// RQ15: Host reads at any rate alongside sampling, keeping sample order.
// RQ16: Host should read status twice and keep the smaller block count.
// RQ17: Host reads one block per burst when count nonzero, else polls empty.
// RQ18: FIFO interrupt enable defaults off and acts only with the jumper.
// RQ19: Each entry is one 16-bit sample, delivered first in first out.
module asf_sample_fifo
    import asf_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
    parameter int FRAG_DEPTH = FRAG_DEPTH_DEF
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    // Configuration
    input wire logic superset_jumper,
    input wire logic queue_irq_enable,
    input wire logic [1:0] irq_block_threshold_sel,
    // Sample stream in
    input wire logic sampleValid,
    input wire logic [15:0] sampleData,
    // Host register port
    input wire asf_bus_t hostBus,
    output logic [15:0] readData,
    output logic ioChannelReady,
    output logic irqOut,
    output asf_status_t status
);
    localparam int AW = $clog2(FIFO_DEPTH);
    localparam int FW = $clog2(FRAG_DEPTH);

    typedef struct packed {
        logic [AW:0] wrPtr;
        logic [AW:0] rdPtr;
        logic [FW:0] fragCnt;
        logic [FW-1:0] fragHead;
        logic irqFlag;
        logic fullFlag;
        logic jumperMeta;
        logic jumperSync;
        logic [15:0] rdData;
    } asf_state_t;

    asf_state_t s_q, s_d;
    logic [15:0] mainMem [FIFO_DEPTH];
    logic [15:0] fragMem [FRAG_DEPTH];

    logic [AW:0] mainCnt;
    logic [AW+1:0] totalCnt;
    logic chanWrite, dataRead, clrWrite, pushMain, moveFrag, fragEmpty, fragPop;
    logic [AW+4:0] threshold;
    logic aboveThresh, jumperOn;
    logic [15:0] fragHeadWord;
    logic [FW-1:0] fragTail;

    function automatic logic hit(input asf_bus_t b, input logic [3:0] ofs);
        hit = b.addr == ofs;
    endfunction : hit

    assign mainCnt = s_q.wrPtr - s_q.rdPtr;
    assign totalCnt = {1'b0, mainCnt} + (AW+2)'(s_q.fragCnt);
    assign chanWrite = hostBus.wr && hit(hostBus, OFS_CHAN);
    assign clrWrite = hostBus.wr && hit(hostBus, OFS_CLRINT);
    assign dataRead = hostBus.rd && hit(hostBus, OFS_DATA);
    assign fragEmpty = s_q.fragCnt == '0;
    // Reads served from the fragment buffer; no stall while it holds data
    assign fragPop = dataRead && !fragEmpty; // RQ13
    assign moveFrag = (mainCnt != '0) && (s_q.fragCnt < (FW+1)'(FRAG_DEPTH)); // RQ15
    assign pushMain = sampleValid && (mainCnt != (AW+1)'(FIFO_DEPTH));
    assign fragTail = s_q.fragHead + FW'(s_q.fragCnt);
    // Threshold doubles per selection step above legacy
    // Three spare bits keep the largest selection from wrapping to zero
    assign threshold = (AW+5)'(LEGACY_THRESH) << irq_block_threshold_sel; // RQ1 RQ2
    assign aboveThresh = (AW+5)'(totalCnt) >= threshold; // RQ1 RQ2
    assign jumperOn = s_q.jumperSync; // RQ11 RQ18
    assign fragHeadWord = fragMem[s_q.fragHead];

    always_comb begin
        s_d = s_q;
        // Jumper is a board pin: two flops before anything reads it
        s_d.jumperMeta = superset_jumper;
        s_d.jumperSync = s_q.jumperMeta;
        if (pushMain) begin
            s_d.wrPtr = s_q.wrPtr + 1'b1;
        end
        if (sampleValid && !pushMain) begin
            s_d.fullFlag = 1'b1; // RQ6
        end
        if (pushMain && mainCnt == (AW+1)'(FIFO_DEPTH - 1)) begin
            s_d.fullFlag = 1'b1; // RQ6
        end
        if (moveFrag) begin
            s_d.rdPtr = s_q.rdPtr + 1'b1;
        end
        s_d.fragCnt = s_q.fragCnt + (FW+1)'(moveFrag) - (FW+1)'(fragPop);
        if (fragPop) begin
            s_d.fragHead = s_q.fragHead + 1'b1;
            s_d.rdData = fragMem[s_q.fragHead]; // RQ19
        end
        if (clrWrite) begin
            s_d.irqFlag = 1'b0; // RQ4
        end
        if (aboveThresh) begin
            s_d.irqFlag = 1'b1; // RQ1 RQ2
        end
        if (chanWrite) begin
            s_d.wrPtr = '0; // RQ12
            s_d.rdPtr = '0;
            s_d.fragCnt = '0;
            s_d.fragHead = '0;
            s_d.fullFlag = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '{default: '0};
        end else if (clkEn) begin
            s_q <= s_d;
            if (pushMain) begin
                mainMem[s_q.wrPtr[AW-1:0]] <= sampleData;
            end
            if (moveFrag) begin
                fragMem[fragTail] <= mainMem[s_q.rdPtr[AW-1:0]];
            end
        end
    end

    always_comb begin
        status.irqFlag = s_q.irqFlag;
        status.fragReady = !fragEmpty; // RQ5
        status.fullFlag = s_q.fullFlag;
        status.emptyFlag = totalCnt == '0; // RQ7
        status.blocks = 12'(totalCnt >> BLOCK_SHIFT); // RQ8
    end

    // Stall only when a read finds the fragment buffer drained but samples pending
    assign ioChannelReady = !(dataRead && fragEmpty && mainCnt != '0); // RQ14
    assign irqOut = s_q.irqFlag && queue_irq_enable && jumperOn; // RQ3 RQ18

    always_comb begin
        readData = s_q.rdData;
        if (hostBus.rd && jumperOn && hit(hostBus, OFS_FLAGS)) begin
            readData = {8'h00, status.irqFlag, status.fragReady, status.fullFlag,
                status.emptyFlag, status.blocks[11:8]}; // RQ10 RQ11
        end else if (hostBus.rd && jumperOn && hit(hostBus, OFS_COUNTLO)) begin
            readData = {8'h00, status.blocks[7:0]}; // RQ9 RQ11
        end
    end

    sequence clrSeq;
        clkEn && clrWrite && !aboveThresh;
    endsequence

    chk_irq_set: assert property (@(posedge sys_clk) disable iff (rst) // RQ1
        clkEn && aboveThresh |=> s_q.irqFlag)
        else $error("interrupt not raised at threshold");
    chk_irq_clear: assert property (@(posedge sys_clk) disable iff (rst) // RQ4
        clrSeq |=> !s_q.irqFlag)
        else $error("interrupt not cleared");
    chk_irq_gate: assert property (@(posedge sys_clk) disable iff (rst) // RQ3
        irqOut |-> queue_irq_enable && jumperOn && status.irqFlag)
        else $error("irq line active without enable");
    chk_chan_reset: assert property (@(posedge sys_clk) disable iff (rst) // RQ12
        clkEn && chanWrite && !sampleValid |=> status.emptyFlag && !status.fullFlag)
        else $error("channel write did not reset fifo");
    chk_empty_flag: assert property (@(posedge sys_clk) disable iff (rst) // RQ7
        status.emptyFlag |-> status.blocks == 12'h000 && !status.fragReady)
        else $error("empty with data present");
    chk_no_wait: assert property (@(posedge sys_clk) disable iff (rst) // RQ13
        status.fragReady |-> ioChannelReady)
        else $error("wait state while fragment ready");
    chk_full_sticky: assert property (@(posedge sys_clk) disable iff (rst) // RQ6
        clkEn && s_q.fullFlag && !chanWrite |=> s_q.fullFlag)
        else $error("full flag dropped");
    chk_frag_order: assert property (@(posedge sys_clk) disable iff (rst) // RQ19
        clkEn && fragPop && !chanWrite |=> s_q.fragHead == $past(s_q.fragHead) + 1'b1)
        else $error("fragment order broken");

    sequence pushSeq;
        clkEn && pushMain && !chanWrite;
    endsequence

    sequence moveSeq;
        clkEn && moveFrag && !chanWrite;
    endsequence

    sequence popSeq;
        clkEn && fragPop && !chanWrite;
    endsequence

    sequence overflowSeq;
        clkEn && sampleValid && !pushMain && !chanWrite;
    endsequence

    sequence holdIrqSeq;
        clkEn && s_q.irqFlag && !clrWrite;
    endsequence

    property pPushAdvance;
        @(posedge sys_clk) disable iff (rst)
        pushSeq |=> s_q.wrPtr == $past(s_q.wrPtr) + 1'b1;
    endproperty
    chk_push_advance: assert property (pPushAdvance) // RQ19
        else $error("write pointer did not advance");

    property pMoveAdvance;
        @(posedge sys_clk) disable iff (rst)
        moveSeq |=> s_q.rdPtr == $past(s_q.rdPtr) + 1'b1;
    endproperty
    chk_move_advance: assert property (pMoveAdvance) // RQ15
        else $error("read pointer did not advance");

    property pMoveFill;
        @(posedge sys_clk) disable iff (rst)
        clkEn && moveFrag && !fragPop && !chanWrite |=> s_q.fragCnt == $past(s_q.fragCnt) + 1'b1;
    endproperty
    chk_move_fill: assert property (pMoveFill) // RQ13
        else $error("fragment buffer did not fill");

    property pPopData;
        @(posedge sys_clk) disable iff (rst)
        popSeq |=> s_q.rdData == $past(fragHeadWord);
    endproperty
    chk_pop_data: assert property (pPopData) // RQ19
        else $error("read word is not the oldest sample");

    property pOverflow;
        @(posedge sys_clk) disable iff (rst)
        overflowSeq |=> s_q.fullFlag;
    endproperty
    chk_overflow_full: assert property (pOverflow) // RQ6
        else $error("dropped sample did not set full");

    property pIrqHold;
        @(posedge sys_clk) disable iff (rst)
        holdIrqSeq |=> s_q.irqFlag;
    endproperty
    chk_irq_hold: assert property (pIrqHold) // RQ4
        else $error("interrupt dropped without clear");

    property pIrqQuiet;
        @(posedge sys_clk) disable iff (rst)
        clkEn && !s_q.irqFlag && !aboveThresh |=> !s_q.irqFlag;
    endproperty
    chk_irq_quiet: assert property (pIrqQuiet) // RQ1
        else $error("interrupt raised below threshold");

    property pFreeze;
        @(posedge sys_clk) disable iff (rst)
        !clkEn |=> s_q == $past(s_q);
    endproperty
    chk_freeze_state: assert property (pFreeze) // RQ15
        else $error("state moved while enable low");

    property pFragBound;
        @(posedge sys_clk) disable iff (rst)
        s_q.fragCnt <= (FW+1)'(FRAG_DEPTH);
    endproperty
    chk_frag_bound: assert property (pFragBound) // RQ13
        else $error("fragment count above depth");

    property pMainBound;
        @(posedge sys_clk) disable iff (rst)
        mainCnt <= (AW+1)'(FIFO_DEPTH);
    endproperty
    chk_main_bound: assert property (pMainBound) // RQ15
        else $error("queue count above depth");

    property pWaitCause;
        @(posedge sys_clk) disable iff (rst)
        !ioChannelReady |-> dataRead && fragEmpty;
    endproperty
    chk_wait_cause: assert property (pWaitCause) // RQ14
        else $error("wait state without drained fragment buffer");

    property pJumperGate;
        @(posedge sys_clk) disable iff (rst)
        !jumperOn |-> !irqOut;
    endproperty
    chk_jumper_gate: assert property (pJumperGate) // RQ18
        else $error("irq line active without jumper");

    property pLegacyRead;
        @(posedge sys_clk) disable iff (rst)
        hostBus.rd && !jumperOn |-> readData == s_q.rdData;
    endproperty
    chk_legacy_read: assert property (pLegacyRead) // RQ11
        else $error("status shown without jumper");

    property pUpperZero;
        @(posedge sys_clk) disable iff (rst)
        hostBus.rd && jumperOn && (hit(hostBus, OFS_FLAGS) || hit(hostBus, OFS_COUNTLO))
            |-> readData[15:8] == 8'h00;
    endproperty
    chk_upper_zero: assert property (pUpperZero) // RQ10
        else $error("status upper byte not zero");

    property pLowByte;
        @(posedge sys_clk) disable iff (rst)
        hostBus.rd && jumperOn && hit(hostBus, OFS_COUNTLO) |-> readData[7:0] == status.blocks[7:0];
    endproperty
    chk_low_byte: assert property (pLowByte) // RQ9
        else $error("block count low byte wrong");

    property pHighNibble;
        @(posedge sys_clk) disable iff (rst)
        hostBus.rd && jumperOn && hit(hostBus, OFS_FLAGS) |-> readData[3:0] == status.blocks[11:8];
    endproperty
    chk_high_nibble: assert property (pHighNibble) // RQ9
        else $error("block count upper bits wrong");

    property pNotEmpty;
        @(posedge sys_clk) disable iff (rst)
        s_q.fragCnt != '0 |-> !status.emptyFlag;
    endproperty
    chk_not_empty: assert property (pNotEmpty) // RQ7
        else $error("empty while fragment holds data");

    property pReadyNotEmpty;
        @(posedge sys_clk) disable iff (rst)
        status.fragReady |-> !status.emptyFlag;
    endproperty
    chk_ready_flag: assert property (pReadyNotEmpty) // RQ5
        else $error("fragment ready while empty");

    property pChanClear;
        @(posedge sys_clk) disable iff (rst)
        clkEn && chanWrite |=> s_q.fragCnt == '0 && s_q.wrPtr == s_q.rdPtr;
    endproperty
    chk_chan_clear: assert property (pChanClear) // RQ12
        else $error("channel write left samples queued");

    property pSyncStage;
        @(posedge sys_clk) disable iff (rst)
        clkEn |=> s_q.jumperSync == $past(s_q.jumperMeta);
    endproperty
    chk_sync_stage: assert property (pSyncStage) // RQ11
        else $error("jumper synchroniser skipped a stage");
endmodule : asf_sample_fifo

// ===== verification/asf_host_model.sv
/*
 Host CPU model: byte-wide register cycles on the device's I/O port.
 Assumes a 10 MHz sys_clk and one-cycle rd/wr strobes taken on the rising edge.
*/
`timescale 1ns/10ps
module asf_host_model
    import asf_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Register port
    output asf_bus_t hostBus,
    input wire logic [15:0] readData,
    input wire logic ioChannelReady
);
    initial hostBus = '0;
    // Status answers in the strobe cycle, data answers after the edge
    task automatic busCycle(input logic w, input logic [3:0] a, input logic [7:0] d,
        output logic [15:0] q);
        @(posedge sys_clk);
        #1 hostBus = '{rd: !w, wr: w, addr: a, wdata: d};
        // Hold the request through any wait states
        #49;
        while (!ioChannelReady) begin
            @(posedge sys_clk);
            #50;
        end
        q = readData;
        @(posedge sys_clk);
        #1 hostBus = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        if (!w && a == OFS_DATA) q = readData;
    endtask : busCycle
    // Status may move during a read, so read twice and keep the smaller count
    task automatic readBlocks(output logic [11:0] n);
        logic [15:0] lo, hi;
        n = 12'hfff;
        for (int i = 0; i < 2; i++) begin
            busCycle(1'b0, OFS_COUNTLO, 8'h00, lo);
            busCycle(1'b0, OFS_FLAGS, 8'h00, hi);
            if ({hi[3:0], lo[7:0]} < n) n = {hi[3:0], lo[7:0]};
        end
    endtask : readBlocks
endmodule : asf_host_model

// ===== verification/testbench.sv
/*
 Self-checking bench for the sample FIFO status block.
 Assumes FIFO_DEPTH reduced to 1024 so that the 1100 samples pushed overflow it and set the full flag.
*/
`timescale 1ns/10ps
module testbench;
    import asf_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, jumper = 1'b1, irqEn = 1'b0, sampleValid = 1'b0;
    logic clkEn = 1'b1;
    logic [1:0] sel = 2'h0;
    logic [15:0] sampleData = 16'h0000, readData, q;
    logic [11:0] n;
    logic ioChannelReady, irqOut;
    asf_bus_t hostBus;
    asf_status_t status;
    int errors = 0, n_compared = 0;
    always #50 sys_clk = ~sys_clk;
    asf_sample_fifo #(.FIFO_DEPTH(1024), .FRAG_DEPTH(16)) u_dut (.sys_clk(sys_clk),
        .rst(rst), .clkEn(clkEn), .superset_jumper(jumper), .queue_irq_enable(irqEn),
        .irq_block_threshold_sel(sel), .sampleValid(sampleValid), .sampleData(sampleData),
        .hostBus(hostBus), .readData(readData), .ioChannelReady(ioChannelReady),
        .irqOut(irqOut), .status(status));
    asf_host_model u_host (.sys_clk(sys_clk), .hostBus(hostBus), .readData(readData),
        .ioChannelReady(ioChannelReady));
    task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic push(input int cnt, input logic [15:0] b);
        for (int i = 0; i < cnt; i++) begin
            @(posedge sys_clk);
            #1 sampleValid = 1'b1;
            sampleData = b + 16'(i);
        end
        @(posedge sys_clk);
        #1 sampleValid = 1'b0;
        sampleData = ~sampleData;
        repeat (4) @(posedge sys_clk);
    endtask : push
    task automatic print_verdict();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    initial begin
        #1_000_000 errors++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge sys_clk);
        u_host.busCycle(1'b0, OFS_FLAGS, 8'h00, q);
        check("flags", q, 16'h0010);
        u_host.busCycle(1'b0, OFS_COUNTLO, 8'h00, q);
        check("countlo", q, 16'h0000);
        push(3, 16'h1230);
        u_host.busCycle(1'b0, OFS_FLAGS, 8'h00, q);
        check("flags", q, 16'h0040);
        check("ready", 16'(ioChannelReady), 16'h0001);
        for (int i = 0; i < 3; i++) begin
            u_host.busCycle(1'b0, OFS_DATA, 8'h00, q);
            check("data", q, 16'h1230 + 16'(i));
        end
        u_host.busCycle(1'b0, OFS_FLAGS, 8'h00, q);
        check("flags", q, 16'h0010);
        clkEn = 1'b0;
        push(2, 16'h7000);
        clkEn = 1'b1;
        u_host.busCycle(1'b0, OFS_FLAGS, 8'h00, q);
        check("frozen", q, 16'h0010);
        push(600, 16'h4000);
        check("blocksport", 16'(status.blocks), 16'h0002);
        u_host.readBlocks(n);
        check("blocks", 16'(n), 16'h0002);
        u_host.busCycle(1'b0, OFS_FLAGS, 8'h00, q);
        check("flags", q, 16'h00c0);
        check("irqoff", 16'(irqOut), 16'h0000);
        irqEn = 1'b1;
        #1 check("irqon", 16'(irqOut), 16'h0001);
        jumper = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 check("nojumper", 16'(irqOut), 16'h0000);
        u_host.busCycle(1'b0, OFS_FLAGS, 8'h00, q);
        check("legacy", q, 16'h1232);
        jumper = 1'b1;
        sel = 2'h1;
        repeat (3) @(posedge sys_clk);
        u_host.busCycle(1'b1, OFS_CLRINT, 8'h5a, q);
        u_host.busCycle(1'b0, OFS_FLAGS, 8'h00, q);
        check("clear", q, 16'h0040);
        push(500, 16'h8000);
        u_host.busCycle(1'b0, OFS_FLAGS, 8'h00, q);
        check("fullirq", 16'(q[7:4]), 16'h000e);
        u_host.busCycle(1'b1, OFS_CHAN, 8'h00, q);
        u_host.busCycle(1'b1, OFS_CLRINT, 8'h00, q);
        u_host.busCycle(1'b0, OFS_FLAGS, 8'h00, q);
        check("chanrst", q, 16'h0010);
        u_host.readBlocks(n);
        check("blocks", 16'(n), 16'h0000);
        print_verdict();
    end
endmodule : testbench
